// *** rtl/qtb_defs.vh ***
`ifndef QTB_DEFS_VH
`define QTB_DEFS_VH

// ==========================================================================
// Instruction register
`define QTB_IR_W        4
`define QTB_IR_EXTEST   4'h0
`define QTB_IR_SAMPLE   4'h1
`define QTB_IR_HIGHZ    4'h2
`define QTB_IR_BYPASS   4'hf
`define QTB_IR_CAPTURE  4'h1

// ==========================================================================
// Boundary register: pins per subsystem, subsystem count
`define QTB_PINS        4
`define QTB_SUBS        4

// ==========================================================================
// Controller states
`define QTB_ST_W        4
`define QTB_TLR         4'h0
`define QTB_RTI         4'h1
`define QTB_SEL_DR      4'h2
`define QTB_CAP_DR      4'h3
`define QTB_SHF_DR      4'h4
`define QTB_EX1_DR      4'h5
`define QTB_PAU_DR      4'h6
`define QTB_EX2_DR      4'h7
`define QTB_UPD_DR      4'h8
`define QTB_SEL_IR      4'h9
`define QTB_CAP_IR      4'ha
`define QTB_SHF_IR      4'hb
`define QTB_EX1_IR      4'hc
`define QTB_PAU_IR      4'hd
`define QTB_EX2_IR      4'he
`define QTB_UPD_IR      4'hf

`endif

// *** rtl/qtb_tap.v ***
`timescale 1ns/1ps
`default_nettype none
`include "qtb_defs.vh"

// ==========================================================================
// One subsystem test controller, stepped by the sampled test clock edges
module qtb_tap
(
  input  wire                  clock,
  input  wire                  rst_n,
  input  wire                  trst_n,
  input  wire                  tck_rise,
  input  wire                  tck_fall,
  input  wire                  tms,
  input  wire                  tdi,
  input  wire                  test_mode,
  input  wire [`QTB_PINS-1:0]  pin_in,
  input  wire [`QTB_PINS-1:0]  core_out,
  input  wire [`QTB_PINS-1:0]  core_oe_n,
  output reg                   tdo,
  output wire [`QTB_PINS-1:0]  pin_out,
  output wire [`QTB_PINS-1:0]  pin_oe_n
);

  localparam BR_W = 2 * `QTB_PINS;

  reg [`QTB_ST_W-1:0] st_q;
  reg [`QTB_ST_W-1:0] st_d;
  reg [`QTB_IR_W-1:0] irs_q;
  reg [`QTB_IR_W-1:0] ir_q;
  reg                 byp_q;
  reg [BR_W-1:0]      brs_q;
  reg [BR_W-1:0]      bru_q;
  wire                extest;
  wire                highz;
  wire                samp;
  wire                use_byp;

  // Decode; any unassigned code falls into bypass
  assign extest  = test_mode && (ir_q == `QTB_IR_EXTEST);
  assign highz   = test_mode && (ir_q == `QTB_IR_HIGHZ);
  assign samp    = (ir_q == `QTB_IR_SAMPLE) || extest;
  assign use_byp = !samp;

  // Sixteen-state controller next state
  always @*
  begin
    case (st_q)
      `QTB_TLR:    st_d = tms ? `QTB_TLR    : `QTB_RTI;
      `QTB_RTI:    st_d = tms ? `QTB_SEL_DR : `QTB_RTI;
      `QTB_SEL_DR: st_d = tms ? `QTB_SEL_IR : `QTB_CAP_DR;
      `QTB_CAP_DR: st_d = tms ? `QTB_EX1_DR : `QTB_SHF_DR;
      `QTB_SHF_DR: st_d = tms ? `QTB_EX1_DR : `QTB_SHF_DR;
      `QTB_EX1_DR: st_d = tms ? `QTB_UPD_DR : `QTB_PAU_DR;
      `QTB_PAU_DR: st_d = tms ? `QTB_EX2_DR : `QTB_PAU_DR;
      `QTB_EX2_DR: st_d = tms ? `QTB_UPD_DR : `QTB_SHF_DR;
      `QTB_UPD_DR: st_d = tms ? `QTB_SEL_DR : `QTB_RTI;
      `QTB_SEL_IR: st_d = tms ? `QTB_TLR    : `QTB_CAP_IR;
      `QTB_CAP_IR: st_d = tms ? `QTB_EX1_IR : `QTB_SHF_IR;
      `QTB_SHF_IR: st_d = tms ? `QTB_EX1_IR : `QTB_SHF_IR;
      `QTB_EX1_IR: st_d = tms ? `QTB_UPD_IR : `QTB_PAU_IR;
      `QTB_PAU_IR: st_d = tms ? `QTB_EX2_IR : `QTB_PAU_IR;
      `QTB_EX2_IR: st_d = tms ? `QTB_UPD_IR : `QTB_SHF_IR;
      `QTB_UPD_IR: st_d = tms ? `QTB_SEL_DR : `QTB_RTI;
      default:     st_d = `QTB_TLR;
    endcase
  end

  // State, shift, capture and update on test clock rising edge
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q  <= `QTB_TLR;
      irs_q <= {`QTB_IR_W{1'b0}};
      ir_q  <= `QTB_IR_BYPASS;
      byp_q <= 1'b0;
      brs_q <= {BR_W{1'b0}};
      bru_q <= {BR_W{1'b0}};
    end
    else if (!trst_n)
    begin
      st_q <= `QTB_TLR;
      ir_q <= `QTB_IR_BYPASS;
    end
    else if (tck_rise)
    begin
      st_q <= st_d;
      if (st_q == `QTB_TLR)
        ir_q <= `QTB_IR_BYPASS;
      if (st_q == `QTB_CAP_IR)
        irs_q <= `QTB_IR_CAPTURE;
      if (st_q == `QTB_SHF_IR)
        irs_q <= {tdi, irs_q[`QTB_IR_W-1:1]};
      if (st_q == `QTB_UPD_IR)
        ir_q <= irs_q;
      if (st_q == `QTB_CAP_DR)
      begin
        byp_q <= 1'b0;
        if (samp)
          brs_q <= {pin_in, core_out};
      end
      if (st_q == `QTB_SHF_DR)
      begin
        byp_q <= tdi;
        if (samp)
          brs_q <= {tdi, brs_q[BR_W-1:1]};
      end
      if (st_q == `QTB_UPD_DR && samp)
        bru_q <= brs_q;
    end
  end

  // Serial output changes on falling edge
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      tdo <= 1'b0;
    else if (tck_fall)
    begin
      if (st_q == `QTB_SHF_IR)
        tdo <= irs_q[0];
      else if (use_byp)
        tdo <= byp_q;
      else
        tdo <= brs_q[0];
    end
  end

  // Pin drive: update stage under EXTEST, tristate under HIGHZ
  assign pin_out  = extest ? bru_q[`QTB_PINS-1:0] : core_out;
  assign pin_oe_n = highz ? {`QTB_PINS{1'b1}} :
                    extest ? ~bru_q[BR_W-1:`QTB_PINS] : core_oe_n;

endmodule

`default_nettype wire

// *** rtl/qtb_chain.v ***
`timescale 1ns/1ps
`default_nettype none
`include "qtb_defs.vh"

// What this block does
// - Chain order TDI, A, B, C, D, TDO
// - SAMPLE captures and preloads, pins stay functional
// - EXTEST drives pins from update stage
// - BYPASS inserts one bit, pins functional
// - All bypass gives four-bit path
// - HIGHZ selects bypass, tristates all pin outputs
// - No optional instructions beyond those four
// - Shared mode, clock, reset to four controllers
// - Both straps high at reset release enable test
module qtb_chain
(
  input  wire                            clock,
  input  wire                            rst_n,
  input  wire                            tck,
  input  wire                            tms,
  input  wire                            tdi,
  input  wire                            trst_n,
  input  wire                            emulation_strap_zero,
  input  wire                            emulation_strap_one,
  output wire                            tdo,
  output wire                            tdo_oe_n,
  output wire                            test_mode,
  input  wire [`QTB_SUBS*`QTB_PINS-1:0]  pin_in,
  input  wire [`QTB_SUBS*`QTB_PINS-1:0]  core_out,
  input  wire [`QTB_SUBS*`QTB_PINS-1:0]  core_oe_n,
  output wire [`QTB_SUBS*`QTB_PINS-1:0]  pin_out,
  output wire [`QTB_SUBS*`QTB_PINS-1:0]  pin_oe_n
);

  // ========================================================================
  // Pin synchronisers
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  reg       tck_old_q;
  reg       trst_old_q;
  reg       mode_q;
  reg [`QTB_SUBS*`QTB_PINS-1:0] pin_s1_q;
  reg [`QTB_SUBS*`QTB_PINS-1:0] pin_s2_q;
  wire      tck_s;
  wire      tms_s;
  wire      tdi_s;
  wire      trst_s;
  wire      strap_s;
  wire      tck_rise;
  wire      tck_fall;
  wire [`QTB_SUBS:0] link;

  // Two stages on every pin from the tester
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
    end
    else
    begin
      s1_q <= {tck, tms, tdi, trst_n,
               emulation_strap_zero & emulation_strap_one};
      s2_q <= s1_q;
    end
  end

  // Two stages on the pin levels before any boundary cell captures them
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_q <= {(`QTB_SUBS*`QTB_PINS){1'b0}};
      pin_s2_q <= {(`QTB_SUBS*`QTB_PINS){1'b0}};
    end
    else
    begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign tck_s   = s2_q[4];
  assign tms_s   = s2_q[3];
  assign tdi_s   = s2_q[2];
  assign trst_s  = s2_q[1];
  assign strap_s = s2_q[0];

  // Edge finders on the synchronised test clock and reset
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tck_old_q  <= 1'b0;
      trst_old_q <= 1'b0;
    end
    else
    begin
      tck_old_q  <= tck_s;
      trst_old_q <= trst_s;
    end
  end

  assign tck_rise = tck_s & ~tck_old_q;
  assign tck_fall = ~tck_s & tck_old_q;

  // ========================================================================
  // Test mode latched at the rising edge of test reset
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      mode_q <= 1'b0;
    else if (trst_s & ~trst_old_q)
      mode_q <= strap_s;
  end

  assign test_mode = mode_q;

  // ========================================================================
  // Four controllers, A nearest input, D nearest output
  assign link[0] = tdi_s;

  genvar g;
  generate
    for (g = 0; g < `QTB_SUBS; g = g + 1)
    begin : g_sub
      qtb_tap u_tap
      (
        .clock     (clock),
        .rst_n     (rst_n),
        .trst_n    (trst_s),
        .tck_rise  (tck_rise),
        .tck_fall  (tck_fall),
        .tms       (tms_s),
        .tdi       (link[g]),
        .test_mode (mode_q),
        .pin_in    (pin_s2_q[g*`QTB_PINS +: `QTB_PINS]),
        .core_out  (core_out[g*`QTB_PINS +: `QTB_PINS]),
        .core_oe_n (core_oe_n[g*`QTB_PINS +: `QTB_PINS]),
        .tdo       (link[g+1]),
        .pin_out   (pin_out[g*`QTB_PINS +: `QTB_PINS]),
        .pin_oe_n  (pin_oe_n[g*`QTB_PINS +: `QTB_PINS])
      );
    end
  endgenerate

  assign tdo      = link[`QTB_SUBS];
  assign tdo_oe_n = 1'b0;

endmodule

`default_nettype wire

// *** dv/qtb_chain_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port properties of the scan chain
module qtb_chain_props
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        tck,
  input wire logic        trst_n,
  input wire logic        emulation_strap_zero,
  input wire logic        emulation_strap_one,
  input wire logic        tdo,
  input wire logic        tdo_oe_n,
  input wire logic        test_mode,
  input wire logic [15:0] core_out,
  input wire logic [15:0] core_oe_n,
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe_n
);
  wire straps = emulation_strap_zero & emulation_strap_one;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Pin control, test mode entry and serial output timing
  chk_pins_pass: assert property (
    !test_mode |-> pin_out == core_out && pin_oe_n == core_oe_n)
    else $error("pins left functional mode");
  chk_tdo_driven: assert property (tdo_oe_n == 1'b0)
    else $error("serial output not driven");
  chk_reset_vals: assert property ($rose(rst_n) |-> !tdo && !test_mode)
    else $error("bad values after reset");
  chk_mode_steady: assert property (trst_n [*8] |=> $stable(test_mode))
    else $error("test mode moved without test reset edge");
  chk_mode_rise: assert property ($rose(test_mode) |-> straps && $past(straps, 3))
    else $error("test mode entered without both straps");
  chk_mode_fall: assert property ($fell(test_mode) |-> !straps)
    else $error("test mode left with both straps high");
  chk_tdo_idle: assert property ((!tck && trst_n) [*6] |=> $stable(tdo))
    else $error("serial output moved while clock idle");
  chk_tdo_rise: assert property ($rose(tck) |=> $stable(tdo) [*4])
    else $error("serial output moved after rising edge");
  // Main scenarios
  cover property ($rose(test_mode));
  cover property (test_mode && pin_oe_n == 16'hffff);
  cover property (test_mode && pin_out[3:0] != core_out[3:0]);
endmodule
bind qtb_chain qtb_chain_props chk_u (.clock(clock), .rst_n(rst_n), .tck(tck), .trst_n(trst_n),
  .emulation_strap_zero(emulation_strap_zero), .emulation_strap_one(emulation_strap_one),
  .tdo(tdo), .tdo_oe_n(tdo_oe_n), .test_mode(test_mode), .core_out(core_out),
  .core_oe_n(core_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
`default_nettype wire

// *** dv/qtb_tester.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Tester model: test clock runs only inside steps, used by scans and test resets
module qtb_tester
(
  input  wire logic clock,
  input  wire logic tdo,
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n,
  output var  logic strap_zero,
  output var  logic strap_one
);
  // Idle levels: clock low, straps high
  initial
    {tck, tms, tdi, trst_n, strap_zero, strap_one} = 6'h1b;
  // One test clock period, output taken before the rise
  task automatic step(input logic t, input logic d, output logic o);
    @(posedge clock) {tms, tdi} <= {t, d};
    repeat (5) @(posedge clock);
    o = tdo;
    tck <= 1'b1;
    repeat (5) @(posedge clock);
    tck <= 1'b0;
  endtask
  // Scan of n bits from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = 32'h0;
    step(1'b1, 1'b0, o);
    if (ir)
      step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // Test reset pulse, straps held across its rising edge
  task automatic treset(input logic s0, input logic s1);
    logic o;
    @(posedge clock) {strap_zero, strap_one, trst_n} <= {s0, s1, 1'b0};
    repeat (8) @(posedge clock);
    trst_n <= 1'b1;
    repeat (8) @(posedge clock);
    step(1'b0, 1'b0, o);
  endtask
endmodule
`default_nettype wire

// *** dv/qtb_chain_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "qtb_defs.vh"
// ==========================================
// Self-checking bench of the scan chain
`define QTB_CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  mismatches++; $display("unexpected %s expected %h seen %h", what, exp, got); end end
module qtb_chain_bench;
  logic        clock, rst_n, tck, tms, tdi, trst_n, s0, s1, tdo, tdo_oe_n, test_mode;
  logic [15:0] pin_in, core_out, core_oe_n, pin_out, pin_oe_n;
  logic [31:0] d;
  int          mismatches, comparisons, cycles;
  // System clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  qtb_tester tst_u (.clock(clock), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .strap_zero(s0), .strap_one(s1));
  qtb_chain dut_u (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .emulation_strap_zero(s0), .emulation_strap_one(s1), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .test_mode(test_mode), .pin_in(pin_in), .core_out(core_out),
    .core_oe_n(core_oe_n), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  // Verdict and end of run
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      test_done;
    end
  end
  // Entry needs both straps high at the test reset rise
  task t_strap;
    tst_u.treset(1'b1, 1'b0);
    `QTB_CHK("mode", 1'b0, test_mode)
    tst_u.treset(1'b1, 1'b1);
    `QTB_CHK("mode", 1'b1, test_mode)
  endtask
  // Four bypass bits between serial in and out
  task t_bypass;
    tst_u.scan(1'b0, 8, 32'hb5, d);
    `QTB_CHK("bypass", 8'h50, d[7:0])
    `QTB_CHK("pins", core_out, pin_out)
    `QTB_CHK("pin oe", core_oe_n, pin_oe_n)
    `QTB_CHK("tdo oe", 1'b0, tdo_oe_n)
  endtask
  // A samples and preloads; odd codes in B and D bypass
  task t_sample;
    tst_u.scan(1'b1, 16, {`QTB_IR_SAMPLE, 4'h7, `QTB_IR_BYPASS, 4'h5}, d);
    `QTB_CHK("ir capture", 16'h1111, d[15:0])
    tst_u.scan(1'b0, 11, {21'h0, 8'h5a, 3'h0}, d);
    `QTB_CHK("sample", {4'he, 4'h4, 3'h0}, d[10:0])
    `QTB_CHK("pins", core_out, pin_out)
    `QTB_CHK("pin oe", core_oe_n, pin_oe_n)
  endtask
  // A drives its pins from the preload, others stay functional
  task t_extest;
    tst_u.scan(1'b1, 16, {`QTB_IR_EXTEST, {3{`QTB_IR_BYPASS}}}, d);
    `QTB_CHK("out", 4'ha, pin_out[3:0])
    `QTB_CHK("oe", 4'ha, pin_oe_n[3:0])
    `QTB_CHK("others", core_out[15:4], pin_out[15:4])
    `QTB_CHK("others oe", core_oe_n[15:4], pin_oe_n[15:4])
  endtask
  // All controllers float their pins and bypass
  task t_highz;
    tst_u.scan(1'b1, 16, {4{`QTB_IR_HIGHZ}}, d);
    `QTB_CHK("float", 16'hffff, pin_oe_n)
    tst_u.scan(1'b0, 8, 32'h0d, d);
    `QTB_CHK("path", 8'hd0, d[7:0])
  endtask
  // Main sequence
  initial
  begin
    {rst_n, mismatches, comparisons, cycles} = '0;
    {pin_in, core_out, core_oe_n} = {16'h9c3e, 16'h1234, 16'h0f0f};
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    `QTB_CHK("mode", 1'b0, test_mode)
    t_strap;
    t_bypass;
    t_sample;
    t_extest;
    t_highz;
    test_done;
  end
endmodule
`default_nettype wire
